// ### core/spfc_pkg.sv
// package for the self-program flash control block
// assumes one core clock; register reached over avalon-mm, 32-bit data
package spfc_pkg;

    // ***************************************************************
    // register map
    // ***************************************************************
    localparam logic [7:0] REG_INDEX     = 8'h37;
    localparam logic [9:0] REG_BYTE_ADDR = 10'h0DC;
    localparam logic [7:0] REG_RESET     = 8'h00;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int BIT_IRQ_EN   = 7;
    localparam int BIT_BUSY     = 6;
    localparam int BIT_RSVD     = 5;
    localparam int BIT_READ_EN  = 4;
    localparam int BIT_LOCK_SET = 3;
    localparam int BIT_PG_WRITE = 2;
    localparam int BIT_PG_ERASE = 1;
    localparam int BIT_ENABLE   = 0;

    // ***************************************************************
    // accepted patterns in the lower five bits, and the cleared value PAT_NONE
    // ***************************************************************
    localparam logic [4:0] PAT_READ_EN  = 5'h11;
    localparam logic [4:0] PAT_LOCK_SET = 5'h09;
    localparam logic [4:0] PAT_PG_WRITE = 5'h05;
    localparam logic [4:0] PAT_PG_ERASE = 5'h03;
    localparam logic [4:0] PAT_FILL     = 5'h01;
    localparam logic [4:0] PAT_NONE     = 5'h00;

    // ***************************************************************
    // timing counts, in core clock cycles
    // ***************************************************************
    localparam logic [2:0] ARM_CYCLES  = 3'h4;
    localparam logic [2:0] LOAD_CYCLES = 3'h3;
    localparam logic [2:0] LOAD_FLOOR  = ARM_CYCLES - LOAD_CYCLES;

    // ***************************************************************
    // carriers
    // ***************************************************************
    typedef struct packed {
        logic        store;
        logic        load;
        logic [15:0] exec_word;
        logic [15:0] pointer;
        logic [15:0] data;
    } spfc_core_t;

    typedef struct packed {
        logic        valid;
        logic        erase;
        logic        write;
        logic [15:0] word_addr;
    } spfc_flash_t;

endpackage

// ### core/spfc_top.sv
// self-program flash control: control/status register, arming window,
// temporary page buffer, page erase/write launch, core halt and ready irq.
// assumes the core, the flash macro and the bus master share i_sys_clk.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
module spfc_top
    import spfc_pkg::*;
#(
    parameter int          RWW_SUPPORT       = 0,
    parameter int          PAGE_WORDS        = 32,
    parameter logic [15:0] FLASH_WORDS       = 16'h0800,
    parameter logic [15:0] HALTING_SECTION_START_WORD   = 16'h0600,
    parameter logic [15:0] LOADER_BASE_WORDS = 16'h0080
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_resetn,
    // avalon-mm slave
    input  wire logic [9:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [3:0]  i_avs_byteenable,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // processor core
    input  wire spfc_core_t  i_core,
    input  wire logic        i_global_irq_en,
    input  wire logic        i_eeprom_busy,
    output logic      [7:0]  o_load_data,
    output logic             o_load_valid,
    output logic             o_core_halt,
    output logic             o_ready_irq,
    // fuses and lock bits, high means programmed
    input  wire logic [1:0]  i_loader_size_fuses,
    input  wire logic [7:0]  i_lock_programmed,
    input  wire logic [7:0]  i_fuse_programmed,
    // flash macro
    output spfc_flash_t      o_flash_req,
    input  wire logic        i_flash_done,
    input  wire logic [$clog2(PAGE_WORDS)-1:0] i_buf_rd_idx,
    output logic      [15:0] o_buf_rd_word
);

    localparam int IDX_W = $clog2(PAGE_WORDS);

    // ***************************************************************
    // state
    // ***************************************************************
    logic                    ack_q;
    logic [31:0]             rdata_q;
    logic                    irq_en_q;
    logic                    irq_en_d;
    logic [4:0]              low_q;
    logic [4:0]              low_d;
    logic [2:0]              cnt_q;
    logic [2:0]              cnt_d;
    logic                    op_busy_q;
    logic                    op_write_q;
    logic                    busy_flag_q;
    logic                    halt_q;
    logic                    filling_q;
    logic                    irq_q;
    logic [7:0]              load_data_q;
    logic                    load_valid_q;
    spfc_flash_t             flash_q;
    logic [15:0]             buf_word_q;
    logic [15:0]             page_buf_q [PAGE_WORDS];

    // ***************************************************************
    // decode
    // ***************************************************************
    wire        req_any     = i_avs_read | i_avs_write;
    wire        addr_hit    = (i_avs_address == REG_BYTE_ADDR);
    wire        write_hit   = i_avs_write & ack_q & addr_hit & i_avs_byteenable[0];
    wire [4:0]  wpat        = i_avs_writedata[4:0];
    wire        pat_ok      = (wpat == PAT_READ_EN) || (wpat == PAT_LOCK_SET) ||
                              (wpat == PAT_PG_WRITE) || (wpat == PAT_PG_ERASE) ||
                              (wpat == PAT_FILL);
    wire        arm_write   = write_hit & pat_ok & ~op_busy_q;
    wire        mode_fill   = (low_q == PAT_FILL);
    wire        mode_erase  = (low_q == PAT_PG_ERASE);
    wire        mode_write  = (low_q == PAT_PG_WRITE);
    wire        mode_rd_en  = (low_q == PAT_READ_EN);
    wire        mode_lock   = (low_q == PAT_LOCK_SET);
    wire [15:0] loader_size = LOADER_BASE_WORDS << (2'h3 - i_loader_size_fuses);
    wire [15:0] loader_base = FLASH_WORDS - loader_size;
    wire        in_loader   = (i_core.exec_word >= loader_base);
    wire        window_open = (cnt_q != 3'h0);
    wire        store_ok    = i_core.store & low_q[BIT_ENABLE] & window_open
                              & in_loader & ~op_busy_q;
    wire        page_start  = store_ok & (mode_erase | mode_write);
    wire [15:0] target_word = {1'b0, i_core.pointer[15:1]};
    wire [15:0] page_word   = target_word & ~(16'(PAGE_WORDS) - 16'h0001);
    wire        in_halting  = (target_word >= HALTING_SECTION_START_WORD);
    wire        lock_load   = i_core.load & mode_lock & (cnt_q > LOAD_FLOOR);
    wire [IDX_W-1:0] fill_idx = i_core.pointer[IDX_W:1];
    wire        clear_buf   = (arm_write & (wpat == PAT_READ_EN) & filling_q)
                              | (op_busy_q & op_write_q & i_flash_done);
    wire        busy_rd     = (RWW_SUPPORT != 0) & busy_flag_q;
    wire [7:0]  reg_value   = {irq_en_q, busy_rd, 1'b0, low_q};
    wire [31:0] rdata_d     = addr_hit ? {24'h0000_00, reg_value} : 32'h0000_0000;
    wire        irq_d       = irq_en_q & i_global_irq_en & ~low_q[BIT_ENABLE]
                              & ~i_eeprom_busy & ~op_busy_q;

    // ***************************************************************
    // control bits and arming window
    // ***************************************************************
    always_comb begin
        irq_en_d = irq_en_q;
        low_d    = low_q;
        cnt_d    = window_open ? cnt_q - 3'h1 : 3'h0;
        if (op_busy_q) begin
            if (i_flash_done) begin
                low_d = PAT_NONE;
            end
        end else if (store_ok) begin
            if (!page_start) begin
                low_d = PAT_NONE;
            end
        end else if (cnt_q == 3'h1) begin
            low_d = PAT_NONE;
        end
        if (write_hit) begin
            irq_en_d = i_avs_writedata[BIT_IRQ_EN];
        end
        if (arm_write) begin
            low_d = wpat;
            cnt_d = ARM_CYCLES;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_en_q <= REG_RESET[BIT_IRQ_EN];
            low_q    <= REG_RESET[4:0];
            cnt_q    <= 3'h0;
        end else begin
            irq_en_q <= irq_en_d;
            low_q    <= low_d;
            cnt_q    <= cnt_d;
        end
    end

    // ***************************************************************
    // avalon slave: one wait cycle, then answer
    // ***************************************************************
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= req_any & ~ack_q;
            rdata_q <= rdata_d;
        end
    end

    // ***************************************************************
    // page operations, halt and busy flag
    // ***************************************************************
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            op_busy_q   <= 1'b0;
            op_write_q  <= 1'b0;
            busy_flag_q <= 1'b0;
            halt_q      <= 1'b0;
            flash_q     <= '0;
        end else begin
            flash_q.valid <= page_start;
            if (page_start) begin
                flash_q.erase     <= mode_erase;
                flash_q.write     <= mode_write;
                flash_q.word_addr <= page_word;
                op_busy_q         <= 1'b1;
                op_write_q        <= mode_write;
                halt_q            <= (RWW_SUPPORT == 0) | in_halting;
                busy_flag_q       <= (RWW_SUPPORT != 0) & ~in_halting;
            end else if (op_busy_q && i_flash_done) begin
                op_busy_q <= 1'b0;
                halt_q    <= 1'b0;
            end else if (store_ok && mode_rd_en) begin
                busy_flag_q <= 1'b0;
            end
        end
    end

    // ***************************************************************
    // temporary page buffer
    // ***************************************************************
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            filling_q <= 1'b0;
            for (int i = 0; i < PAGE_WORDS; i++) begin
                page_buf_q[i] <= 16'hFFFF;
            end
        end else if (clear_buf) begin
            filling_q <= 1'b0;
            for (int i = 0; i < PAGE_WORDS; i++) begin
                page_buf_q[i] <= 16'hFFFF;
            end
        end else if (store_ok && mode_fill) begin
            filling_q            <= 1'b1;
            page_buf_q[fill_idx] <= i_core.data;
        end
    end

    // ***************************************************************
    // lock and fuse read-back, irq, buffer read port
    // ***************************************************************
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            load_data_q  <= 8'h00;
            load_valid_q <= 1'b0;
            irq_q        <= 1'b0;
            buf_word_q   <= 16'h0000;
        end else begin
            load_valid_q <= lock_load;
            if (lock_load) begin
                load_data_q <= i_core.pointer[0] ? ~i_fuse_programmed
                                                 : ~i_lock_programmed;
            end
            irq_q      <= irq_d;
            buf_word_q <= page_buf_q[i_buf_rd_idx];
        end
    end

    assign o_avs_readdata    = rdata_q;
    assign o_avs_waitrequest = ~ack_q;
    assign o_load_data       = load_data_q;
    assign o_load_valid      = load_valid_q;
    assign o_core_halt       = halt_q;
    assign o_ready_irq       = irq_q;
    assign o_flash_req       = flash_q;
    assign o_buf_rd_word     = buf_word_q;

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_lock_armed;
        arm_write && (wpat == PAT_LOCK_SET);
    endsequence

    sequence s_page_op_done;
        op_busy_q && i_flash_done;
    endsequence

    a_irq_request_on: assert property (irq_d |=> o_ready_irq)
        else $error("ready irq not raised");
    a_irq_busy_off: assert property ((op_busy_q || i_eeprom_busy) |=> !o_ready_irq)
        else $error("ready irq during operation");
    a_busy_small_zero: assert property ((RWW_SUPPORT == 0) |-> !o_avs_readdata[BIT_BUSY])
        else $error("busy flag nonzero on small variant");
    a_reserved_bit_zero: assert property (!o_avs_readdata[BIT_RSVD])
        else $error("reserved bit nonzero");
    a_buffer_clear_fill: assert property (arm_write && (wpat == PAT_READ_EN) |=> !filling_q)
        else $error("buffer not cleared");
    a_lock_load_read: assert property (s_lock_armed ##1 (i_core.load && !i_core.pointer[0])
        |=> o_load_valid && (o_load_data == ~$past(i_lock_programmed)))
        else $error("lock bits not returned");
    a_write_launch: assert property (store_ok && mode_write
        |=> o_flash_req.valid && o_flash_req.write && op_busy_q)
        else $error("page write not launched");
    a_erase_launch: assert property (store_ok && mode_erase |=> o_flash_req.erase)
        else $error("page erase not launched");
    a_op_done_clear: assert property (s_page_op_done and (!write_hit) |=> low_q == PAT_NONE)
        else $error("mode bits not cleared at completion");
    a_window_expiry: assert property (arm_write ##1 (!i_core.store && !write_hit) [*4]
        |=> low_q == PAT_NONE)
        else $error("arming window did not expire");
    a_enable_held: assert property (op_busy_q && !i_flash_done |=> low_q[BIT_ENABLE])
        else $error("enable dropped during operation");
    a_small_halt: assert property (page_start && (RWW_SUPPORT == 0) |=> o_core_halt)
        else $error("core not halted");
    a_app_store_ignored: assert property (i_core.store && !in_loader |=> !o_flash_req.valid)
        else $error("store from application acted");
    a_bad_pattern: assert property (write_hit && !pat_ok && !op_busy_q && cnt_q == 3'h0
        |=> $stable(low_q))
        else $error("invalid pattern took effect");

endmodule

// ### verif/spfc_core_model.sv
// processor core model: issues store-to-flash and program memory loads
// assumes it shares i_sys_clk with the flash control block and the bench
`timescale 1ns/100ps
module spfc_core_model
    import spfc_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_core_halt,
    input  wire logic       i_load_valid,
    input  wire logic [7:0] i_load_data,
    output spfc_core_t      o_core,
    output logic      [7:0] o_last_load
);
    // ***********************************
    // load capture and instruction issue
    // ***********************************
    initial begin
        o_core      = '0;
        o_last_load = 8'h00;
    end
    always @(posedge i_sys_clk) begin
        if (i_resetn === 1'b1 && i_load_valid === 1'b1) begin
            o_last_load <= i_load_data;
        end
    end
    task automatic issue(input logic st, input logic ld, input logic [15:0] pc,
                         input logic [15:0] ptr, input logic [15:0] dat);
        integer n;
        n = 0;
        while (i_core_halt !== 1'b0 && n < 2000) begin // stalled core waits
            @(posedge i_sys_clk);
            n = n + 1;
        end
        o_core.store     <= st;
        o_core.load      <= ld;
        o_core.exec_word <= pc;
        o_core.pointer   <= ptr;
        o_core.data      <= dat;
        @(posedge i_sys_clk);
        o_core.store   <= 1'b0;
        o_core.load    <= 1'b0;
        o_core.pointer <= ~ptr; // stale operands, never the old value
        o_core.data    <= ~dat;
    endtask
endmodule

// ### verif/testbench.sv
// self-checking bench for the self-program flash control block
// assumes the package and the core model are compiled first
`timescale 1ns/100ps
module testbench
    import spfc_pkg::*;
;
    localparam logic [15:0] LDR = 16'h07F0;
    localparam logic [15:0] APP = 16'h0010;
    logic        clk, resetn, avs_read, avs_write, avs_waitrequest;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic        global_en, ee_busy, load_valid, core_halt, ready_irq, flash_done;
    logic [7:0]  load_data, last_load, rd;
    logic [4:0]  buf_idx;
    logic [15:0] buf_word;
    spfc_core_t  core;
    spfc_flash_t flash_req, req_seen;
    int          failures, num_checks, n_req;

    spfc_top u_dut (.i_sys_clk(clk), .i_resetn(resetn), .i_avs_address(avs_address),
        .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_byteenable(4'h1),
        .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
        .o_avs_waitrequest(avs_waitrequest), .i_core(core), .i_global_irq_en(global_en),
        .i_eeprom_busy(ee_busy), .o_load_data(load_data), .o_load_valid(load_valid),
        .o_core_halt(core_halt), .o_ready_irq(ready_irq), .i_loader_size_fuses(2'h3),
        .i_lock_programmed(8'h3C), .i_fuse_programmed(8'h81), .o_flash_req(flash_req),
        .i_flash_done(flash_done), .i_buf_rd_idx(buf_idx), .o_buf_rd_word(buf_word));
    spfc_core_model u_core (.i_sys_clk(clk), .i_resetn(resetn), .i_core_halt(core_halt),
        .i_load_valid(load_valid), .i_load_data(load_data), .o_core(core),
        .o_last_load(last_load));

    // ***********************************
    // clock, request monitor, tasks
    // ***********************************
    initial clk = 1'b0;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (flash_req.valid === 1'b1) begin
            n_req = n_req + 1;
            req_seen = flash_req;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        integer n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= {24'h00_0000, d};
        do begin
            @(posedge clk);
            n = n + 1;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) failures = failures + 1;
        rd = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] d);
        bus(1'b1, REG_BYTE_ADDR, d);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] e);
        bus(1'b0, REG_BYTE_ADDR, 8'h00);
        chk(nm, {8'h00, e}, {8'h00, rd});
    endtask
    task automatic bufchk(input logic [4:0] i, input logic [15:0] e);
        buf_idx <= i;
        cyc(2);
        chk("buffer word", e, buf_word);
    endtask
    task automatic done_pulse();
        flash_done <= 1'b1;
        @(posedge clk);
        flash_done <= 1'b0;
        cyc(3);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ***********************************
    // tests
    // ***********************************
    initial begin
        resetn = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = '0;
        avs_writedata = '0; global_en = 1'b1; ee_busy = 1'b0; flash_done = 1'b0;
        buf_idx = '0; failures = 0; num_checks = 0; n_req = 0; req_seen = '0;
        cyc(6);
        resetn <= 1'b1;
        rdchk("reset value", REG_RESET);
        bus(1'b0, 10'h0D8, 8'h00);
        chk("unmapped read", 16'h0000, {8'h00, rd});
        bus(1'b1, 10'h0D8, 8'h80);
        rdchk("unmapped write", 8'h00);
        wr(8'hFF);
        rdchk("read-only bits", 8'h80);
        cyc(3);
        chk("irq on", 16'h0001, {15'h0, ready_irq});
        ee_busy <= 1'b1;
        cyc(3);
        chk("irq eeprom", 16'h0000, {15'h0, ready_irq});
        ee_busy <= 1'b0;
        global_en <= 1'b0;
        cyc(3);
        chk("irq global", 16'h0000, {15'h0, ready_irq});
        global_en <= 1'b1;
        $display("test registers and irq done");
        wr(8'h01);
        u_core.issue(1'b1, 1'b0, LDR, 16'h000B, 16'h1234);
        rdchk("enable cleared", 8'h00);
        bufchk(5'd5, 16'h1234);
        wr(8'h01);
        u_core.issue(1'b1, 1'b0, APP, 16'h000C, 16'h5555);
        bufchk(5'd6, 16'hFFFF);
        wr(8'h01);
        cyc(5);
        rdchk("window expiry", 8'h00);
        u_core.issue(1'b1, 1'b0, LDR, 16'h000E, 16'h7777);
        bufchk(5'd7, 16'hFFFF);
        wr(8'h11);
        cyc(5);
        bufchk(5'd5, 16'hFFFF);
        $display("test buffer fill done");
        wr(8'h83);
        u_core.issue(1'b1, 1'b0, LDR, 16'h0F46, 16'h9999);
        cyc(3);
        chk("erase count", 16'h0001, n_req[15:0]);
        chk("erase kind", 16'h0002, {14'h0, req_seen.erase, req_seen.write});
        chk("erase page", 16'h07A0, req_seen.word_addr);
        chk("halt erase", 16'h0001, {15'h0, core_halt});
        chk("irq busy", 16'h0000, {15'h0, ready_irq});
        cyc(6);
        rdchk("enable held", 8'h83);
        done_pulse();
        chk("halt released", 16'h0000, {15'h0, core_halt});
        rdchk("erase cleared", 8'h80);
        cyc(2);
        chk("irq ready", 16'h0001, {15'h0, ready_irq});
        $display("test page erase done");
        wr(8'h01);
        u_core.issue(1'b1, 1'b0, LDR, 16'h0006, 16'h5A5A);
        wr(8'h05);
        u_core.issue(1'b1, 1'b0, LDR, 16'h0086, 16'hDEAD);
        cyc(3);
        chk("write count", 16'h0002, n_req[15:0]);
        chk("write kind", 16'h0001, {14'h0, req_seen.erase, req_seen.write});
        chk("write page", 16'h0040, req_seen.word_addr);
        chk("halt write", 16'h0001, {15'h0, core_halt});
        rdchk("write held", 8'h05);
        done_pulse();
        chk("halt write end", 16'h0000, {15'h0, core_halt});
        rdchk("write cleared", 8'h00);
        bufchk(5'd3, 16'hFFFF);
        foreach (u_core.o_last_load[i]) begin
            if (i < 4) begin
                wr(8'h03 + 8'(i[0]) * 8'h02 + 8'(i[1]) * 8'h04);
                cyc(6);
                rdchk("armed expiry", 8'h00);
            end
        end
        chk("no late request", 16'h0002, n_req[15:0]);
        $display("test page write done");
        wr(8'h09);
        u_core.issue(1'b0, 1'b1, LDR, 16'h0000, 16'h0000);
        cyc(2);
        chk("lock bits", 16'h00C3, {8'h00, last_load});
        wr(8'h09);
        u_core.issue(1'b0, 1'b1, LDR, 16'h0001, 16'h0000);
        cyc(2);
        chk("fuse bits", 16'h007E, {8'h00, last_load});
        $display("test lock read done");
        give_verdict();
    end
    initial begin
        cyc(20000);
        failures = failures + 1;
        give_verdict();
    end
endmodule
